// >>> ors_pkg.sv
// ors_pkg: shared constants and types of the overload status reporting block.
// assumes a single 100 MHz system clock shared by every user of this package.
package ors_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_MIN_NS = 1000;
    // least time, so round up
    localparam int PULSE_CYCLES = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int OVL_WIDTH = 3;
    localparam int OVL_BIT_INPUT = 0;
    localparam int OVL_BIT_SUM = 1;
    localparam int OVL_BIT_OUTPUT = 2;
    localparam int CE_WIDTH = 8;
    localparam int SUM_BIT_OVERLOAD = 0;
    localparam int SUM_BIT_COMM = 1;
    localparam int SUM_BIT_STD = 2;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic PULSE_MODE_OFF = 1'b0;
    localparam logic PULSE_MODE_ON = 1'b1;

    // ------------------------------------------------------------------
    // last key codes
    // ------------------------------------------------------------------
    localparam logic [3:0] KEY_NONE = 4'h0;
    localparam logic [3:0] KEY_POLARITY = 4'h1;
    localparam logic [3:0] KEY_GAIN_UP = 4'h2;
    localparam logic [3:0] KEY_GAIN_DOWN = 4'h3;
    localparam logic [3:0] KEY_OFFSET_UP = 4'h4;
    localparam logic [3:0] KEY_OFFSET_DOWN = 4'h5;
    localparam logic [3:0] KEY_GAIN_RESET = 4'h6;
    localparam logic [3:0] KEY_OFFSET_RESET = 4'h7;
    localparam logic [3:0] KEY_AUTOCAL = 4'h8;

    // ------------------------------------------------------------------
    // host commands
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_OVL_READ = 4'b0000,
        CMD_OVL_MASK_WRITE = 4'b0001,
        CMD_OVL_MASK_READ = 4'b0010,
        CMD_CE_READ = 4'b0011,
        CMD_CE_MASK_WRITE = 4'b0100,
        CMD_CE_MASK_READ = 4'b0101,
        CMD_PULSE_WRITE = 4'b0110,
        CMD_PULSE_READ = 4'b0111,
        CMD_KEY_READ = 4'b1000,
        CMD_SUMMARY_QUERY = 4'b1001,
        CMD_CLEAR_ALL = 4'b1010
    } ors_cmd_type;

endpackage : ors_pkg

// >>> ors_pulse.sv
// ors_pulse: stretches a one-cycle start into an active-high pulse of fixed least length.
// assumes start is a one-cycle pulse synchronous to clk_sys.
module ors_pulse #(
    parameter int CYCLES = ors_pkg::PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // control
    input wire logic start,
    output logic active
);

    logic [15:0] count;
    logic [15:0] next_count;

    // a new start while running restarts the full length
    always_comb begin
        next_count = count;
        if (start) begin
            next_count = 16'(CYCLES);
        end else if (count != 16'h0000) begin
            next_count = count - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count <= 16'h0000;
        end else begin
            count <= next_count;
        end
    end

    assign active = (count != 16'h0000);

endmodule : ors_pulse

// >>> ors_status.sv
// ors_status: overload and communication-error status, service request line,
// pulse mode and last key code of an instrument module.
// assumes the command parser delivers one decoded command per cmd_valid pulse.

// Summary of operation
// - reading overload register clears exactly the bits returned by that read
// - overload mask writable and readable, whole word or one indexed bit
// - comm error mask writable and readable, whole word or one indexed bit
// - pulse mode encoded 0 off (latched), 1 on (pulsed), writable and readable
// - pulse mode on: each new request drives request line low at least 1 us
// - pulse mode off: request line held low until full summary byte query
// - pulse mode powers up off; command reset leaves it unchanged
// - key codes 1 polarity, 2-3 gain keys, 4-5 offset keys
// - combined keys: 6 gain reset, 7 offset reset, 8 autocalibrate
// - unindexed summary query releases latched request line; indexed query leaves it
// - reading last key code clears it to 0
// - clear-all clears standard event, comm error and overload registers
module ors_status (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic command_reset,
    // host command
    input wire logic cmd_valid,
    input wire ors_pkg::ors_cmd_type cmd_code,
    input wire logic cmd_indexed,
    input wire logic [2:0] cmd_index,
    input wire logic [7:0] cmd_data,
    // host response
    output logic resp_valid,
    output logic [7:0] resp_data,
    // event sources
    input wire logic overload_input,
    input wire logic overload_sum,
    input wire logic overload_output,
    input wire logic [7:0] comm_error_set,
    input wire logic key_valid,
    input wire logic [3:0] key_code,
    input wire logic std_event_summary,
    // status outputs
    output logic std_event_clear,
    output logic service_request_n
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [2:0] overload_event_register;
    logic [2:0] next_overload_event_register;
    logic [2:0] overload_prev;
    logic [7:0] overload_event_mask;
    logic [7:0] next_overload_event_mask;
    logic [7:0] comm_error_register;
    logic [7:0] next_comm_error_register;
    logic [7:0] comm_error_mask;
    logic [7:0] next_comm_error_mask;
    logic pulse_request_mode;
    logic next_pulse_request_mode;
    logic [3:0] last_key_code;
    logic [3:0] next_last_key_code;
    logic request_latched;
    logic next_request_latched;
    logic request_prev;
    logic next_resp_valid;
    logic [7:0] next_resp_data;
    logic next_std_event_clear;
    logic [2:0] overload_now;
    logic [2:0] overload_rise;
    logic [7:0] summary_byte;
    logic request_now;
    logic request_new;
    logic pulse_active;

    // whole word, or only the indexed bit
    function automatic logic [7:0] sel_bits(input logic indexed, input logic [2:0] idx);
        sel_bits = indexed ? (8'h01 << idx) : 8'hFF;
    endfunction : sel_bits

    // answer is the whole word, or the indexed bit moved to bit 0
    function automatic logic [7:0] read_value(input logic [7:0] word, input logic indexed,
                                              input logic [2:0] idx);
        read_value = indexed ? {7'h00, word[idx]} : word;
    endfunction : read_value

    // writes whole word, or the indexed bit from bit 0 of the data
    function automatic logic [7:0] write_value(input logic [7:0] word, input logic indexed,
                                               input logic [2:0] idx, input logic [7:0] data);
        logic [7:0] m;
        m = sel_bits(indexed, idx);
        write_value = indexed ? ((word & ~m) | ({8{data[0]}} & m)) : data;
    endfunction : write_value

    // ------------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------------
    always_comb begin
        overload_now = 3'b000;
        overload_now[ors_pkg::OVL_BIT_INPUT] = overload_input;
        overload_now[ors_pkg::OVL_BIT_SUM] = overload_sum;
        overload_now[ors_pkg::OVL_BIT_OUTPUT] = overload_output;
    end

    // rising edge only, so a persisting overload does not refill a cleared flag
    assign overload_rise = overload_now & ~overload_prev;

    always_comb begin
        summary_byte = 8'h00;
        summary_byte[ors_pkg::SUM_BIT_OVERLOAD] =
            |({5'h00, overload_event_register} & overload_event_mask);
        summary_byte[ors_pkg::SUM_BIT_COMM] = |(comm_error_register & comm_error_mask);
        summary_byte[ors_pkg::SUM_BIT_STD] = std_event_summary;
    end

    assign request_now = |summary_byte;
    assign request_new = request_now & ~request_prev;

    // ------------------------------------------------------------------
    // command execution
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] sel;
        sel = sel_bits(cmd_indexed, cmd_index);
        next_overload_event_register = overload_event_register;
        next_overload_event_mask = overload_event_mask;
        next_comm_error_register = comm_error_register;
        next_comm_error_mask = comm_error_mask;
        next_pulse_request_mode = pulse_request_mode;
        next_last_key_code = last_key_code;
        next_request_latched = request_latched;
        next_resp_valid = 1'b0;
        next_resp_data = 8'h00;
        next_std_event_clear = 1'b0;
        if (cmd_valid) begin
            case (cmd_code)
                ors_pkg::CMD_OVL_READ: begin
                    next_resp_valid = 1'b1;
                    next_resp_data = read_value({5'h00, overload_event_register},
                                                cmd_indexed, cmd_index);
                    next_overload_event_register = overload_event_register & ~sel[2:0];
                end
                ors_pkg::CMD_OVL_MASK_WRITE: begin
                    next_overload_event_mask = write_value(overload_event_mask, cmd_indexed,
                                                           cmd_index, cmd_data);
                end
                ors_pkg::CMD_OVL_MASK_READ: begin
                    next_resp_valid = 1'b1;
                    next_resp_data = read_value(overload_event_mask, cmd_indexed,
                                                cmd_index);
                end
                ors_pkg::CMD_CE_READ: begin
                    next_resp_valid = 1'b1;
                    next_resp_data = read_value(comm_error_register, cmd_indexed, cmd_index);
                    next_comm_error_register = comm_error_register & ~sel;
                end
                ors_pkg::CMD_CE_MASK_WRITE: begin
                    next_comm_error_mask = write_value(comm_error_mask, cmd_indexed,
                                                       cmd_index, cmd_data);
                end
                ors_pkg::CMD_CE_MASK_READ: begin
                    next_resp_valid = 1'b1;
                    next_resp_data = read_value(comm_error_mask, cmd_indexed, cmd_index);
                end
                ors_pkg::CMD_PULSE_WRITE: begin
                    next_pulse_request_mode = cmd_data[0];
                end
                ors_pkg::CMD_PULSE_READ: begin
                    next_resp_valid = 1'b1;
                    next_resp_data = {7'h00, pulse_request_mode};
                end
                ors_pkg::CMD_KEY_READ: begin
                    next_resp_valid = 1'b1;
                    next_resp_data = {4'h0, last_key_code};
                    next_last_key_code = ors_pkg::KEY_NONE;
                end
                ors_pkg::CMD_SUMMARY_QUERY: begin
                    next_resp_valid = 1'b1;
                    next_resp_data = read_value(summary_byte, cmd_indexed, cmd_index);
                    if (!cmd_indexed) begin
                        next_request_latched = 1'b0;
                    end
                end
                ors_pkg::CMD_CLEAR_ALL: begin
                    next_overload_event_register = 3'b000;
                    next_comm_error_register = 8'h00;
                    next_std_event_clear = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // new events win over a clear in the same cycle
        next_overload_event_register = next_overload_event_register | overload_rise;
        next_comm_error_register = next_comm_error_register | comm_error_set;
        if (key_valid) begin
            next_last_key_code = key_code;
        end
        // command reset forgets the last key only; masks and pulse mode are kept
        if (command_reset) begin
            next_last_key_code = ors_pkg::KEY_NONE;
        end
        // latched mode only; pulse mode uses the stretcher instead
        if (request_new && pulse_request_mode == ors_pkg::PULSE_MODE_OFF) begin
            next_request_latched = 1'b1;
        end
        if (pulse_request_mode == ors_pkg::PULSE_MODE_ON) begin
            next_request_latched = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            overload_event_register <= 3'b000;
            overload_prev <= 3'b000;
            overload_event_mask <= ors_pkg::MASK_RESET;
            comm_error_register <= 8'h00;
            comm_error_mask <= ors_pkg::MASK_RESET;
            pulse_request_mode <= ors_pkg::PULSE_MODE_OFF;
            last_key_code <= ors_pkg::KEY_NONE;
            request_latched <= 1'b0;
            request_prev <= 1'b0;
            resp_valid <= 1'b0;
            resp_data <= 8'h00;
            std_event_clear <= 1'b0;
        end else begin
            overload_event_register <= next_overload_event_register;
            overload_prev <= overload_now;
            // command reset keeps masks and pulse mode as they are
            overload_event_mask <= next_overload_event_mask;
            comm_error_register <= next_comm_error_register;
            comm_error_mask <= next_comm_error_mask;
            pulse_request_mode <= next_pulse_request_mode;
            last_key_code <= next_last_key_code;
            request_latched <= next_request_latched;
            request_prev <= request_now;
            resp_valid <= next_resp_valid;
            resp_data <= next_resp_data;
            std_event_clear <= next_std_event_clear;
        end
    end

    // ------------------------------------------------------------------
    // service request line
    // ------------------------------------------------------------------
    ors_pulse #(
        .CYCLES(ors_pkg::PULSE_CYCLES)
    ) u_pulse (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(request_new && pulse_request_mode == ors_pkg::PULSE_MODE_ON),
        .active(pulse_active)
    );

    assign service_request_n = ~(request_latched | pulse_active);

endmodule : ors_status

// >>> ors_status_props.sv
// ors_status_props: port checks of the status block, bound to ors_status.
// assumes one clock and a synchronous active-high reset.
module ors_status_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // host side
    input wire logic cmd_valid,
    input wire ors_pkg::ors_cmd_type cmd_code,
    input wire logic cmd_indexed,
    input wire logic [7:0] cmd_data,
    input wire logic resp_valid,
    input wire logic [7:0] resp_data,
    // events and status
    input wire logic key_valid,
    input wire logic std_event_clear,
    input wire logic service_request_n
);
    localparam int PLEN = ors_pkg::PULSE_CYCLES;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic mode;
    logic next_mode;
    int low_cnt;
    int next_low_cnt;
    wire logic sq = cmd_valid && cmd_code == ors_pkg::CMD_SUMMARY_QUERY;
    wire logic kr = cmd_valid && cmd_code == ors_pkg::CMD_KEY_READ && !key_valid;
    // only a latch holds past the pulse length, so a pulse left over from
    // pulse mode cannot be mistaken for a latch
    wire logic held = !mode && !service_request_n && low_cnt > PLEN;
    always_comb begin
        next_mode = mode;
        next_low_cnt = service_request_n ? 0 : low_cnt + 1;
        if (cmd_valid && cmd_code == ors_pkg::CMD_PULSE_WRITE) begin
            next_mode = cmd_data[0];
        end
        if (reset) begin
            next_mode = 1'b0;
            next_low_cnt = 0;
        end
    end
    always_ff @(posedge clk_sys) begin
        mode <= next_mode;
        low_cnt <= next_low_cnt;
    end
    read_answer_a: assert property (
        cmd_valid && cmd_code == ors_pkg::CMD_OVL_READ |=> resp_valid)
        else $error("read not answered");
    resp_cause_a: assert property (resp_valid |-> $past(cmd_valid))
        else $error("answer without command");
    pulse_read_a: assert property (
        cmd_valid && cmd_code == ors_pkg::CMD_PULSE_READ |=> resp_data == {7'h00, mode})
        else $error("pulse mode readback wrong");
    pulse_width_a: assert property (
        mode && $past(mode) && $rose(service_request_n) |-> low_cnt >= PLEN)
        else $error("request pulse too short");
    latch_hold_a: assert property (held && !cmd_valid |=> !service_request_n)
        else $error("latched request released early");
    query_release_a: assert property (held && sq && !cmd_indexed |=> service_request_n)
        else $error("summary query did not release");
    indexed_keep_a: assert property (held && sq && cmd_indexed |=> !service_request_n)
        else $error("indexed query released request");
    clear_pulse_a: assert property (
        cmd_valid && cmd_code == ors_pkg::CMD_CLEAR_ALL |=> std_event_clear)
        else $error("clear-all not passed on");
    key_clear_a: assert property (kr ##1 kr |=> resp_data == 8'h00)
        else $error("key code not cleared");
    pulse_seen_c: cover property (mode && $fell(service_request_n));
    latch_seen_c: cover property (held && sq);
    clear_seen_c: cover property (std_event_clear);
endmodule : ors_status_props

bind ors_status ors_status_props i_ors_status_props (
    .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_indexed(cmd_indexed), .cmd_data(cmd_data),
    .resp_valid(resp_valid), .resp_data(resp_data), .key_valid(key_valid),
    .std_event_clear(std_event_clear), .service_request_n(service_request_n)
);

// >>> ors_host.sv
// ors_host: host model that sends decoded commands and takes the answers.
// assumes every call starts at a falling edge of clk_sys.
module ors_host (
    // clock
    input wire logic clk_sys,
    // command
    output logic cmd_valid,
    output ors_pkg::ors_cmd_type cmd_code,
    output logic cmd_indexed,
    output logic [2:0] cmd_index,
    output logic [7:0] cmd_data,
    // answer
    input wire logic resp_valid,
    input wire logic [7:0] resp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rsp;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = ors_pkg::CMD_OVL_READ;
        cmd_indexed = 1'b0;
        cmd_index = 3'h0;
        cmd_data = 8'h00;
    end
    // the answer stands one cycle only, so it is taken at the next falling edge
    task automatic issue(input ors_pkg::ors_cmd_type code, input logic ix = 1'b0,
            input logic [2:0] idx = 3'h0, input logic [7:0] data = 8'h00);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_indexed = ix;
        cmd_index = idx;
        cmd_data = data;
        @(negedge clk_sys);
        rsp = resp_valid ? resp_data : 8'hxx;
    endtask : issue
    // idle lines flip so a stale value is never read as fresh
    task automatic rest();
        cmd_valid = 1'b0;
        cmd_index = ~cmd_index;
        cmd_data = ~cmd_data;
        @(negedge clk_sys);
    endtask : rest
endmodule : ors_host

// >>> ors_status_tb.sv
// ors_status_tb: self-checking bench of ors_status driven by the host model.
// assumes ors_pkg, ors_status, ors_host and the bound checker compile first.
module ors_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, (g), (e)); end end
    logic clk_sys, reset, command_reset, cmd_valid, cmd_indexed, resp_valid;
    logic overload_input, overload_sum, overload_output, key_valid;
    logic std_event_summary, std_event_clear, service_request_n;
    logic [2:0] cmd_index;
    logic [3:0] key_code;
    logic [7:0] cmd_data, resp_data, comm_error_set;
    ors_pkg::ors_cmd_type cmd_code;
    int n_mismatch, total_checks, n;
    wire logic [7:0] r = i_ors_host.rsp;
    ors_status i_ors_status (
        .clk_sys(clk_sys), .reset(reset), .command_reset(command_reset),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_indexed(cmd_indexed),
        .cmd_index(cmd_index), .cmd_data(cmd_data), .resp_valid(resp_valid),
        .resp_data(resp_data), .overload_input(overload_input),
        .overload_sum(overload_sum), .overload_output(overload_output),
        .comm_error_set(comm_error_set), .key_valid(key_valid), .key_code(key_code),
        .std_event_summary(std_event_summary), .std_event_clear(std_event_clear),
        .service_request_n(service_request_n)
    );
    ors_host i_ors_host (
        .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_indexed(cmd_indexed), .cmd_index(cmd_index), .cmd_data(cmd_data),
        .resp_valid(resp_valid), .resp_data(resp_data)
    );
    task automatic q(input ors_pkg::ors_cmd_type c, input logic ix = 1'b0,
            input logic [2:0] i = 3'h0, input logic [7:0] d = 8'h00);
        i_ors_host.issue(c, ix, i, d);
        i_ors_host.rest();
    endtask : q
    task automatic tick(input int c);
        repeat (c) @(negedge clk_sys);
    endtask : tick
    task automatic t_mask(input ors_pkg::ors_cmd_type w, input ors_pkg::ors_cmd_type rd);
        q(rd);
        `CHK(r, ors_pkg::MASK_RESET)
        q(w, 1'b0, 3'h0, 8'ha5);
        q(w, 1'b1, 3'h1, 8'h01);
        q(rd, 1'b1, 3'h1);
        `CHK(r, 8'h01)
        q(w, 1'b1, 3'h7, 8'h00);
        q(rd);
        `CHK(r, 8'h27)
        q(w);
        $display("test mask done");
    endtask : t_mask
    task automatic t_ovl();
        overload_input = 1'b1;
        overload_output = 1'b1;
        tick(1);
        overload_input = 1'b0;
        overload_output = 1'b0;
        q(ors_pkg::CMD_OVL_READ);
        `CHK(r, 8'h05)
        q(ors_pkg::CMD_OVL_READ);
        `CHK(r, 8'h00)
        overload_sum = 1'b1;
        overload_input = 1'b1;
        tick(2);
        q(ors_pkg::CMD_OVL_READ, 1'b1, 3'h0);
        `CHK(r, 8'h01)
        q(ors_pkg::CMD_OVL_READ);
        `CHK(r, 8'h02)
        overload_sum = 1'b0;
        tick(1);
        overload_sum = 1'b1;
        comm_error_set = 8'h08;
        tick(1);
        comm_error_set = 8'h00;
        i_ors_host.issue(ors_pkg::CMD_CLEAR_ALL);
        `CHK(std_event_clear, 1'b1)
        i_ors_host.rest();
        q(ors_pkg::CMD_OVL_READ);
        `CHK(r, 8'h00)
        q(ors_pkg::CMD_CE_READ);
        `CHK(r, 8'h00)
        overload_sum = 1'b0;
        overload_input = 1'b0;
        $display("test overload done");
    endtask : t_ovl
    task automatic t_latch();
        q(ors_pkg::CMD_OVL_MASK_WRITE, 1'b0, 3'h0, 8'h01);
        overload_input = 1'b1;
        tick(150);
        q(ors_pkg::CMD_SUMMARY_QUERY, 1'b1, 3'h0);
        `CHK(r, 8'h01)
        `CHK(service_request_n, 1'b0)
        q(ors_pkg::CMD_SUMMARY_QUERY);
        `CHK(service_request_n, 1'b1)
        `CHK(r[0], 1'b1)
        overload_input = 1'b0;
        q(ors_pkg::CMD_OVL_READ);
        q(ors_pkg::CMD_OVL_MASK_WRITE);
        std_event_summary = 1'b1;
        tick(3);
        `CHK(service_request_n, 1'b0)
        q(ors_pkg::CMD_SUMMARY_QUERY);
        `CHK(r, 8'h01 << ors_pkg::SUM_BIT_STD)
        `CHK(service_request_n, 1'b1)
        std_event_summary = 1'b0;
        $display("test latch done");
    endtask : t_latch
    task automatic t_keys();
        for (int k = 1; k <= 8; k++) begin
            key_code = 4'(k);
            key_valid = 1'b1;
            tick(1);
            key_valid = 1'b0;
            q(ors_pkg::CMD_KEY_READ);
            `CHK(r, {4'h0, key_code})
        end
        key_code = ors_pkg::KEY_OFFSET_DOWN;
        key_valid = 1'b1;
        tick(1);
        key_valid = 1'b0;
        i_ors_host.issue(ors_pkg::CMD_KEY_READ);
        `CHK(i_ors_host.rsp, {4'h0, ors_pkg::KEY_OFFSET_DOWN})
        i_ors_host.issue(ors_pkg::CMD_KEY_READ);
        i_ors_host.rest();
        `CHK(r, 8'h00)
        $display("test keys done");
    endtask : t_keys
    task automatic t_pulse();
        q(ors_pkg::CMD_PULSE_READ);
        `CHK(r, 8'h00)
        q(ors_pkg::CMD_PULSE_WRITE, 1'b0, 3'h0, 8'h01);
        command_reset = 1'b1;
        tick(1);
        command_reset = 1'b0;
        q(ors_pkg::CMD_PULSE_READ);
        `CHK(r, 8'h01)
        q(ors_pkg::CMD_OVL_MASK_WRITE, 1'b0, 3'h0, 8'h04);
        overload_output = 1'b1;
        n = 0;
        repeat (300) begin
            tick(1);
            n += int'(service_request_n === 1'b0);
        end
        `CHK(n >= ors_pkg::PULSE_CYCLES, 1'b1)
        `CHK(service_request_n, 1'b1)
        overload_output = 1'b0;
        q(ors_pkg::CMD_PULSE_WRITE);
        q(ors_pkg::CMD_PULSE_READ);
        `CHK(r, 8'h00)
        $display("test pulse done");
    endtask : t_pulse
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        reset = 1'b1;
        command_reset = 1'b0;
        overload_input = 1'b0;
        overload_sum = 1'b0;
        overload_output = 1'b0;
        key_valid = 1'b0;
        key_code = 4'h0;
        std_event_summary = 1'b0;
        comm_error_set = 8'h00;
        tick(6);
        reset = 1'b0;
        t_mask(ors_pkg::CMD_OVL_MASK_WRITE, ors_pkg::CMD_OVL_MASK_READ);
        t_mask(ors_pkg::CMD_CE_MASK_WRITE, ors_pkg::CMD_CE_MASK_READ);
        t_ovl();
        t_latch();
        t_keys();
        t_pulse();
        complete_run();
    end
    // the tests need about 560 cycles; some eighteen times that means a hang
    initial begin
        #100_000;
        n_mismatch++;
        complete_run();
    end
endmodule : ors_status_tb
